// *** core/ptmr_params.svh ***
`ifndef PTMR_PARAMS_SVH
`define PTMR_PARAMS_SVH

// Register block selects (address bits 7:4)
`define PTMR_BLK_CTL_EVEN    4'h0
`define PTMR_BLK_CNT_EVEN    4'h1
`define PTMR_BLK_PER_EVEN    4'h2
`define PTMR_BLK_CTL_ODD     4'h4
`define PTMR_BLK_CNT_ODD     4'h5
`define PTMR_BLK_PER_ODD     4'h6

// Alias offsets within a register block (address bits 3:2)
`define PTMR_ALIAS_CLR       8'h04
`define PTMR_ALIAS_SET       8'h08
`define PTMR_ALIAS_INV       8'h0C

// Control field positions
`define PTMR_BIT_ON          15
`define PTMR_BIT_STOP_IN_IDLE        13
`define PTMR_BIT_GATE        7
`define PTMR_BIT_PS_HI       6
`define PTMR_BIT_PS_LO       4
`define PTMR_BIT_WIDE        3
`define PTMR_BIT_TCS         1

// Writable bits of each control register
`define PTMR_CTL_MASK_EVEN   16'hA0FA
`define PTMR_CTL_MASK_ODD    16'hA0F2

// Reset values
`define PTMR_RST_CTL         16'h0000
`define PTMR_RST_CNT         16'h0000
`define PTMR_RST_PER         16'hFFFF

// Prescale terminal values (ratio minus one)
`define PTMR_PS_LIM_1        8'h00
`define PTMR_PS_LIM_2        8'h01
`define PTMR_PS_LIM_4        8'h03
`define PTMR_PS_LIM_8        8'h07
`define PTMR_PS_LIM_16       8'h0F
`define PTMR_PS_LIM_32       8'h1F
`define PTMR_PS_LIM_64       8'h3F
`define PTMR_PS_LIM_256      8'hFF

`endif

// *** core/ptmr_pkg.sv ***
package ptmr_pkg;

   // Kind of register access, from address bits 3:2
   typedef enum logic [1:0] {
      PTMR_OP_WRITE = 2'h0,
      PTMR_OP_CLR   = 2'h1,
      PTMR_OP_SET   = 2'h2,
      PTMR_OP_INV   = 2'h3
   } ptmr_op_t;

   // State of the pair controller
   typedef struct packed {
      logic [15:0] ctl_e;     // Even control
      logic [15:0] ctl_o;     // Odd control
      logic [15:0] cnt_e;     // Even count
      logic [15:0] cnt_o;     // Odd count
      logic [15:0] per_e;     // Even period
      logic [15:0] per_o;     // Odd period
      logic [31:0] rdata;     // Read data
      logic        flag_e;    // Even period match pulse
      logic        flag_o;    // Odd period match pulse
   } ptmr_state_t;

   // State of a prescaler
   typedef struct packed {
      logic [7:0] cnt;        // Input tick count
   } ptmr_ps_state_t;

   // State of an edge detector
   typedef struct packed {
      logic prev;             // Last pin level
   } ptmr_edge_state_t;

endpackage

// *** core/ptmr_edge.sv ***
// Rising edge detector for a timer clock pin
module ptmr_edge
   import ptmr_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic resetn,
   input  wire logic pin,
   output wire logic rise
);

   ptmr_edge_state_t s_q;   // Registered state
   ptmr_edge_state_t s_d;   // Next state

   // Remember the pin level
   always_comb
   begin
      s_d      = s_q;
      s_d.prev = pin;
   end

   // Register the state
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   // Pulse on a low to high change
   assign rise = pin & ~s_q.prev;

endmodule

// *** core/ptmr_prescale.sv ***
`include "ptmr_params.svh"

// Input tick prescaler, ratios 1 to 256
module ptmr_prescale
   import ptmr_pkg::*;
#(
   parameter int CNT_W = 8
)
(
   input  wire logic       ref_clk,
   input  wire logic       resetn,
   input  wire logic       clear,
   input  wire logic       tick,
   input  wire logic [2:0] sel,
   output wire logic       pulse
);

   // The counter must hold the largest ratio
   initial
   begin
      if (CNT_W != 8)
         $error("ptmr_prescale: CNT_W must be 8");
   end

   // Terminal count for a prescale selection
   function automatic logic [7:0] ps_limit(input logic [2:0] s);
      unique case (s)
         3'h0: ps_limit = `PTMR_PS_LIM_1;
         3'h1: ps_limit = `PTMR_PS_LIM_2;
         3'h2: ps_limit = `PTMR_PS_LIM_4;
         3'h3: ps_limit = `PTMR_PS_LIM_8;
         3'h4: ps_limit = `PTMR_PS_LIM_16;
         3'h5: ps_limit = `PTMR_PS_LIM_32;
         3'h6: ps_limit = `PTMR_PS_LIM_64;
         3'h7: ps_limit = `PTMR_PS_LIM_256;
      endcase
   endfunction

   ptmr_ps_state_t s_q;     // Registered state
   ptmr_ps_state_t s_d;     // Next state
   logic           at_lim;  // Counter at or past terminal value

   assign at_lim = (s_q.cnt >= ps_limit(sel));

   // [RQ5] Divide the input ticks
   always_comb
   begin
      s_d = s_q;
      if (clear)
         s_d.cnt = 8'h00;
      else if (tick)
         s_d.cnt = at_lim ? 8'h00 : s_q.cnt + 8'h01;
   end

   // Register the state
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   // One pulse per completed ratio
   assign pulse = tick & at_lim & ~clear;

endmodule

// *** core/ptmr_pair.sv ***
// The address map and strobed register access were left to the implementer.
`include "ptmr_params.svh"

// Notes on behaviour
// [RQ1] Timer runs only while enable bit set
// [RQ2] Stop-in-idle halts the timer during idle
// [RQ3] External clock: gate bit ignored, reads zero
// [RQ4] Internal clock with gate: count while gate high
// [RQ5] Prescale field divides by 1..256
// [RQ6] Wide mode joins even and odd timers
// [RQ7] Wide mode bit exists only on even timer
// [RQ8] Wide mode: odd timer settings ignored; code still halts the wide timer on odd stop-in-idle
// [RQ9] Software clears odd stop-in-idle for wide idle run
// [RQ10] Clock source: pin or internal clock
// [RQ11] Unimplemented bits ignore writes, read zero
// [RQ12] Software skips access right after disable
// [RQ13] Pairing fixed: even timer with next odd
// [RQ14] Clear, set, invert aliases at +4/+8/+C
// [RQ15] Count per tick, wrap at period, flag
module ptmr_pair
   import ptmr_pkg::*;
#(
   parameter int EVEN_INDEX = 2
)
(
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   input  wire logic [7:0]  bus_addr,
   input  wire logic [31:0] bus_wdata,
   input  wire logic        bus_write,
   input  wire logic        bus_read,
   output wire logic [31:0] bus_rdata,
   input  wire logic        device_idle,
   input  wire logic        ext_timer_clock_pin_even,
   input  wire logic        ext_timer_clock_pin_odd,
   output wire logic        period_flag_even,
   output wire logic        period_flag_odd
);

   // [RQ13] Pairing fixed to an even timer and the next one
   initial
   begin
      if (EVEN_INDEX != 2 && EVEN_INDEX != 4)
         $error("ptmr_pair: EVEN_INDEX must be 2 or 4");
   end

   // Apply a plain, clear, set or invert write under a mask
   function automatic logic [15:0] reg_write(
      input logic [15:0] old,
      input logic [15:0] wd,
      input ptmr_op_t    op,
      input logic [15:0] mask
   );
      logic [15:0] nv;
      nv = old;
      unique case (op)
         PTMR_OP_WRITE: nv = wd;
         PTMR_OP_CLR:   nv = old & ~wd;
         PTMR_OP_SET:   nv = old | wd;
         PTMR_OP_INV:   nv = old ^ wd;
      endcase
      reg_write = (nv & mask) | (old & ~mask);
   endfunction

   // Input tick for one timer from its source settings
   function automatic logic src_tick(
      input logic clock_source_select,
      input logic gate,
      input logic rise,
      input logic level
   );
      if (clock_source_select)
         src_tick = rise;
      else if (gate)
         src_tick = level;
      else
         src_tick = 1'b1;
   endfunction

   // Readable image of a control register
   function automatic logic [31:0] ctl_view(input logic [15:0] c);
      logic [15:0] v;
      v = c;
      // [RQ3] Gate bit reads zero with external clock
      if (c[`PTMR_BIT_TCS])
         v[`PTMR_BIT_GATE] = 1'b0;
      ctl_view = {16'h0000, v};
   endfunction

   ptmr_state_t s_q;            // Registered state
   ptmr_state_t s_d;            // Next state

   // Bus decode
   logic [3:0]  blk;            // Register block select
   ptmr_op_t    op;             // Access kind
   logic        addr_ok;        // Low address bits clear
   logic [15:0] wd16;           // Low half of write data

   // Control field views
   logic        wide;           // Pair runs as one 32-bit timer
   logic        run_e;          // Even timer running
   logic        run_o;          // Odd timer running
   logic        tick_e;         // Even input tick
   logic        tick_o;         // Odd input tick
   logic        ps_e;           // Even prescaled tick
   logic        ps_o;           // Odd prescaled tick
   logic        rise_e;         // Even pin rising edge
   logic        rise_o;         // Odd pin rising edge
   logic        clr_ps_e;       // Hold even prescaler at zero
   logic        clr_ps_o;       // Hold odd prescaler at zero
   logic [31:0] cnt_w;          // Joined count
   logic [31:0] per_w;          // Joined period

   assign blk     = bus_addr[7:4];
   assign op      = ptmr_op_t'(bus_addr[3:2]);
   assign addr_ok = (bus_addr[1:0] == 2'h0);
   assign wd16    = bus_wdata[15:0];

   // [RQ6] Wide mode taken from the even control only
   assign wide = s_q.ctl_e[`PTMR_BIT_WIDE];

   // [RQ1] Even timer enable and idle stop
   // [RQ2] Halt in idle when stop-in-idle set
   // [RQ9] Odd stop-in-idle also halts the wide timer
   assign run_e = s_q.ctl_e[`PTMR_BIT_ON]
                  & ~(device_idle & s_q.ctl_e[`PTMR_BIT_STOP_IN_IDLE])
                  & ~(wide & device_idle & s_q.ctl_o[`PTMR_BIT_STOP_IN_IDLE]);

   // [RQ8] Odd enable ignored in wide mode
   assign run_o = ~wide & s_q.ctl_o[`PTMR_BIT_ON]
                  & ~(device_idle & s_q.ctl_o[`PTMR_BIT_STOP_IN_IDLE]);

   // [RQ10] Select pin edge or internal clock
   // [RQ4] Gated accumulation while pin high
   assign tick_e = run_e & src_tick(s_q.ctl_e[`PTMR_BIT_TCS],
                                    s_q.ctl_e[`PTMR_BIT_GATE],
                                    rise_e,
                                    ext_timer_clock_pin_even);
   assign tick_o = run_o & src_tick(s_q.ctl_o[`PTMR_BIT_TCS],
                                    s_q.ctl_o[`PTMR_BIT_GATE],
                                    rise_o,
                                    ext_timer_clock_pin_odd);

   // Prescalers restart whenever their timer is off
   assign clr_ps_e = ~s_q.ctl_e[`PTMR_BIT_ON];
   assign clr_ps_o = ~s_q.ctl_o[`PTMR_BIT_ON] | wide;

   assign cnt_w = {s_q.cnt_o, s_q.cnt_e};
   assign per_w = {s_q.per_o, s_q.per_e};

   // Edge detector on the even pin
   ptmr_edge u_edge_e (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .pin     (ext_timer_clock_pin_even),
      .rise    (rise_e)
   );

   // Edge detector on the odd pin
   ptmr_edge u_edge_o (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .pin     (ext_timer_clock_pin_odd),
      .rise    (rise_o)
   );

   // Even prescaler, also serves the wide timer
   ptmr_prescale #(
      .CNT_W (8)
   ) u_ps_e (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .clear   (clr_ps_e),
      .tick    (tick_e),
      .sel     (s_q.ctl_e[`PTMR_BIT_PS_HI:`PTMR_BIT_PS_LO]),
      .pulse   (ps_e)
   );

   // Odd prescaler, idle in wide mode
   ptmr_prescale #(
      .CNT_W (8)
   ) u_ps_o (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .clear   (clr_ps_o),
      .tick    (tick_o),
      .sel     (s_q.ctl_o[`PTMR_BIT_PS_HI:`PTMR_BIT_PS_LO]),
      .pulse   (ps_o)
   );

   // Counting, register writes and read data
   always_comb
   begin
      s_d        = s_q;
      s_d.flag_e = 1'b0;
      s_d.flag_o = 1'b0;
      s_d.rdata  = 32'h0000_0000;

      // [RQ15] Advance per prescaled tick, wrap at period
      if (wide)
      begin
         // Joined count; odd flag marks the wide match
         if (ps_e)
         begin
            if (cnt_w == per_w)
            begin
               s_d.cnt_e  = 16'h0000;
               s_d.cnt_o  = 16'h0000;
               s_d.flag_o = 1'b1;
            end
            else
            begin
               s_d.cnt_e = cnt_w[15:0] + 16'h0001;
               s_d.cnt_o = cnt_w[31:16] + {15'h0000, &cnt_w[15:0]};
            end
         end
      end
      else
      begin
         // Even timer alone
         if (ps_e)
         begin
            if (s_q.cnt_e == s_q.per_e)
            begin
               s_d.cnt_e  = 16'h0000;
               s_d.flag_e = 1'b1;
            end
            else
               s_d.cnt_e = s_q.cnt_e + 16'h0001;
         end
         // Odd timer alone
         if (ps_o)
         begin
            if (s_q.cnt_o == s_q.per_o)
            begin
               s_d.cnt_o  = 16'h0000;
               s_d.flag_o = 1'b1;
            end
            else
               s_d.cnt_o = s_q.cnt_o + 16'h0001;
         end
      end

      // [RQ14] Software writes, with alias operations
      if (bus_write && addr_ok)
      begin
         unique case (blk)
            // [RQ7] Wide bit only in the even mask
            // [RQ11] Unimplemented bits kept at zero
            `PTMR_BLK_CTL_EVEN:
               s_d.ctl_e = reg_write(s_q.ctl_e, wd16, op, `PTMR_CTL_MASK_EVEN);
            `PTMR_BLK_CTL_ODD:
               s_d.ctl_o = reg_write(s_q.ctl_o, wd16, op, `PTMR_CTL_MASK_ODD);
            `PTMR_BLK_CNT_EVEN:
               s_d.cnt_e = reg_write(s_q.cnt_e, wd16, op, 16'hFFFF);
            `PTMR_BLK_CNT_ODD:
               s_d.cnt_o = reg_write(s_q.cnt_o, wd16, op, 16'hFFFF);
            `PTMR_BLK_PER_EVEN:
               s_d.per_e = reg_write(s_q.per_e, wd16, op, 16'hFFFF);
            `PTMR_BLK_PER_ODD:
               s_d.per_o = reg_write(s_q.per_o, wd16, op, 16'hFFFF);
            default:
               s_d.rdata = 32'h0000_0000;
         endcase
      end

      // Reads answer in the following cycle; aliases read zero
      if (bus_read && addr_ok && op == PTMR_OP_WRITE)
      begin
         unique case (blk)
            // [RQ3] Gate reads zero under external clock
            `PTMR_BLK_CTL_EVEN: s_d.rdata = ctl_view(s_q.ctl_e);
            `PTMR_BLK_CTL_ODD:  s_d.rdata = ctl_view(s_q.ctl_o);
            `PTMR_BLK_CNT_EVEN: s_d.rdata = {16'h0000, s_q.cnt_e};
            `PTMR_BLK_CNT_ODD:  s_d.rdata = {16'h0000, s_q.cnt_o};
            `PTMR_BLK_PER_EVEN: s_d.rdata = {16'h0000, s_q.per_e};
            `PTMR_BLK_PER_ODD:  s_d.rdata = {16'h0000, s_q.per_o};
            default:            s_d.rdata = 32'h0000_0000;
         endcase
      end
   end

   // Register the state
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         s_q        <= '0;
         s_q.ctl_e  <= `PTMR_RST_CTL;
         s_q.ctl_o  <= `PTMR_RST_CTL;
         s_q.cnt_e  <= `PTMR_RST_CNT;
         s_q.cnt_o  <= `PTMR_RST_CNT;
         s_q.per_e  <= `PTMR_RST_PER;
         s_q.per_o  <= `PTMR_RST_PER;
      end
      else
         s_q <= s_d;
   end

   // Outputs straight from flip-flops
   assign bus_rdata        = s_q.rdata;
   assign period_flag_even = s_q.flag_e;
   assign period_flag_odd  = s_q.flag_o;

endmodule

// *** bench/ptmr_pair_props.sv ***
module ptmr_pair_props
   import ptmr_pkg::*;
#(
   parameter int EVEN_INDEX = 2
)
(
   input wire logic        ref_clk,
   input wire logic        resetn,
   input wire logic [7:0]  bus_addr,
   input wire logic [31:0] bus_wdata,
   input wire logic        bus_write,
   input wire logic        bus_read,
   input wire logic [31:0] bus_rdata,
   input wire logic        device_idle,
   input wire logic        ext_timer_clock_pin_even,
   input wire logic        ext_timer_clock_pin_odd,
   input wire logic        period_flag_even,
   input wire logic        period_flag_odd
);
   timeunit 1ns;
   timeprecision 1ns;

   logic on_q;   // Shadow of the even enable bit
   logic on_d;   // Next shadow value

   // Follow plain, clear, set and invert writes to the even control word
   always_comb
   begin
      on_d = on_q;
      if (bus_write && bus_addr[7:4] == 4'h0 && bus_addr[1:0] == 2'h0)
         case (bus_addr[3:2])
            2'h0:    on_d = bus_wdata[15];
            2'h1:    on_d = on_q & ~bus_wdata[15];
            2'h2:    on_d = on_q | bus_wdata[15];
            default: on_d = on_q ^ bus_wdata[15];
         endcase
   end

   // Register the shadow
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
         on_q <= 1'b0;
      else
         on_q <= on_d;
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);

   // Read of either control word
   sequence s_rd_ctl;
      bus_read && (bus_addr == 8'h00 || bus_addr == 8'h40);
   endsequence

   // Read of the even control word
   sequence s_rd_even;
      bus_read && bus_addr == 8'h00;
   endsequence

   chk_rdata_idle: assert property (!$past(bus_read) |-> bus_rdata == 32'h0)
      else $error("read data not zero outside a read answer");
   chk_upper_zero: assert property (bus_rdata[31:16] == 16'h0)
      else $error("upper read half not zero");
   chk_ctl_reserved: assert property (s_rd_ctl |=> (bus_rdata & ~32'h0000A0FA) == 32'h0)
      else $error("unimplemented control bit reads one");
   chk_odd_wide_zero: assert property (bus_read && bus_addr == 8'h40 |=> !bus_rdata[3])
      else $error("odd wide bit reads one");
   chk_gate_ext_zero: assert property (s_rd_ctl |=> !(bus_rdata[1] && bus_rdata[7]))
      else $error("gate bit reads one with pin clock");
   chk_unmapped_zero: assert property (bus_read && !(bus_addr inside
      {8'h00, 8'h10, 8'h20, 8'h40, 8'h50, 8'h60}) |=> bus_rdata == 32'h0)
      else $error("unmapped or alias read not zero");
   chk_on_readback: assert property (s_rd_even |=> bus_rdata[15] == $past(on_q))
      else $error("enable bit readback wrong");
   chk_flag_pulse: assert property (period_flag_even |=> !period_flag_even)
      else $error("period flag longer than one cycle");
   chk_off_quiet: assert property (!$past(on_q) && !$past(on_q, 2) && !$past(on_q, 3)
      |-> !period_flag_even)
      else $error("period flag while disabled");
endmodule

bind ptmr_pair ptmr_pair_props #(.EVEN_INDEX(EVEN_INDEX)) u_props (
   .ref_clk                  (ref_clk),
   .resetn                   (resetn),
   .bus_addr                 (bus_addr),
   .bus_wdata                (bus_wdata),
   .bus_write                (bus_write),
   .bus_read                 (bus_read),
   .bus_rdata                (bus_rdata),
   .device_idle              (device_idle),
   .ext_timer_clock_pin_even (ext_timer_clock_pin_even),
   .ext_timer_clock_pin_odd  (ext_timer_clock_pin_odd),
   .period_flag_even         (period_flag_even),
   .period_flag_odd          (period_flag_odd)
);

// *** bench/ptmr_pin_model.sv ***
// Timer clock or gate pin driven from outside the device
module ptmr_pin_model
#(
   parameter int HALF = 3
)
(
   input  wire logic ref_clk,
   input  wire logic run,
   output logic      pin
);
   timeunit 1ns;
   timeprecision 1ns;

   int phase;   // Cycles since the last toggle

   // Pin rests low before the first burst
   initial
   begin
      pin = 1'b0;
      phase = 0;
   end

   // Toggle off the sampling edge; rest low between bursts
   always @(negedge ref_clk)
   begin
      if (!run)
      begin
         pin <= 1'b0;
         phase <= 0;
      end
      else if (phase == HALF - 1)
      begin
         pin <= ~pin;
         phase <= 0;
      end
      else
         phase <= phase + 1;
   end
endmodule

// *** bench/paired_general_timer_control_bench.sv ***
module paired_general_timer_control_bench;
   timeunit 1ns;
   timeprecision 1ns;

   logic        ref_clk;           // Peripheral clock
   logic        resetn;            // Synchronous reset
   logic [7:0]  bus_addr;          // Register address
   logic [31:0] bus_wdata;         // Write data
   logic        bus_write;         // Write strobe
   logic        bus_read;          // Read strobe
   logic [31:0] bus_rdata;         // Read data
   logic        device_idle;       // Idle mode request
   logic        pin_run;           // Pin model burst enable
   logic        ext_pin;           // Pin shared by both timers
   logic        period_flag_even;  // Even match pulse
   logic        period_flag_odd;   // Odd match pulse
   int          miscompares;       // Mismatch count
   int          num_checks;        // Comparison count
   int          cycles;            // Run length guard
   int          flag_hits;         // Even match pulses seen
   int          flag_odd_hits;     // Odd match pulses seen

   ptmr_pair #(
      .EVEN_INDEX(2)
   ) u_dut (
      .ref_clk                  (ref_clk),
      .resetn                   (resetn),
      .bus_addr                 (bus_addr),
      .bus_wdata                (bus_wdata),
      .bus_write                (bus_write),
      .bus_read                 (bus_read),
      .bus_rdata                (bus_rdata),
      .device_idle              (device_idle),
      .ext_timer_clock_pin_even (ext_pin),
      .ext_timer_clock_pin_odd  (ext_pin),
      .period_flag_even         (period_flag_even),
      .period_flag_odd          (period_flag_odd)
   );

   ptmr_pin_model #(
      .HALF(3)
   ) u_pin (
      .ref_clk (ref_clk),
      .run     (pin_run),
      .pin     (ext_pin)
   );

   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Single-cycle register write
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      bus_write <= 1'b1;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge ref_clk);
      bus_write <= 1'b0;
   endtask

   // Single-cycle register read, data checked in the answer cycle
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge ref_clk);
      bus_read <= 1'b1;
      bus_addr <= a;
      @(posedge ref_clk);
      bus_read <= 1'b0;
      @(negedge ref_clk);
      check(bus_rdata, exp);
   endtask

   // Enable for w running edges, then disable and leave a quiet cycle
   task automatic run(input logic [31:0] ctl, input int w);
      wr(8'h00, ctl);
      repeat (w - 2) @(posedge ref_clk);
      wr(8'h00, 32'h0);
      @(posedge ref_clk);
   endtask

   // Verdict and end of run
   task automatic report_and_stop();
      if (miscompares == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Clock
   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // Count match pulses and cut a hang short
   always @(posedge ref_clk)
   begin
      cycles++;
      if (period_flag_even === 1'b1)
         flag_hits++;
      if (period_flag_odd === 1'b1)
         flag_odd_hits++;
      if (cycles == 20000)
      begin
         miscompares++;
         report_and_stop();
      end
   end

   // Main sequence
   initial
   begin
      int r;
      resetn = 1'b0;
      bus_addr = 8'h00;
      bus_wdata = 32'h0;
      bus_write = 1'b0;
      bus_read = 1'b0;
      device_idle = 1'b0;
      pin_run = 1'b0;
      repeat (5) @(posedge ref_clk);
      resetn <= 1'b1;
      rd(8'h00, 32'h0);
      rd(8'h20, 32'h0000FFFF);
      wr(8'h00, 32'hFFFFFFFF);
      rd(8'h00, 32'h0000A07A);
      wr(8'h40, 32'hFFFFFFFF);
      rd(8'h40, 32'h0000A072);
      wr(8'h00, 32'h0);
      wr(8'h40, 32'h0);
      wr(8'h08, 32'h00000070);
      wr(8'h04, 32'h00000030);
      wr(8'h0C, 32'h000000C0);
      rd(8'h00, 32'h00000080);
      rd(8'h0C, 32'h0);
      rd(8'h30, 32'h0);
      rd(8'h01, 32'h0);
      wr(8'h00, 32'h0);
      for (int s = 0; s < 8; s++)
      begin
         r = (s == 7) ? 256 : (1 << s);
         wr(8'h10, 32'h0);
         run(32'h00008000 | (s << 4), 3 * r + r / 2);
         rd(8'h10, 32'h00000003);
      end
      @(posedge ref_clk);
      device_idle <= 1'b1;
      wr(8'h10, 32'h0);
      run(32'h0000A000, 6);
      rd(8'h10, 32'h0);
      run(32'h00008000, 6);
      rd(8'h10, 32'h00000006);
      @(posedge ref_clk);
      device_idle <= 1'b0;
      pin_run <= 1'b1;
      wr(8'h10, 32'h0);
      run(32'h00008082, 30);
      rd(8'h10, 32'h00000005);
      wr(8'h10, 32'h0);
      run(32'h00008080, 36);
      rd(8'h10, 32'h00000012);
      @(posedge ref_clk);
      pin_run <= 1'b0;
      wr(8'h10, 32'h0000FFFE);
      wr(8'h50, 32'h0);
      wr(8'h40, 32'h00000072);
      run(32'h00008008, 5);
      rd(8'h10, 32'h00000003);
      rd(8'h50, 32'h00000001);
      wr(8'h40, 32'h0);
      wr(8'h20, 32'h00000002);
      wr(8'h10, 32'h0);
      flag_hits = 0;
      run(32'h00008000, 9);
      rd(8'h10, 32'h0);
      check(32'(flag_hits), 32'h00000003);
      // Odd timer alone, period one, six running edges
      wr(8'h60, 32'h00000001);
      wr(8'h50, 32'h0);
      flag_odd_hits = 0;
      wr(8'h40, 32'h00008000);
      repeat (4) @(posedge ref_clk);
      wr(8'h40, 32'h0);
      @(posedge ref_clk);
      rd(8'h50, 32'h0);
      check(32'(flag_odd_hits), 32'h00000003);
      report_and_stop();
   end
endmodule
